// >>> include/reset_seq_defs.svh
/*
 * Constants of the reset and self-test sequencer: register word indexes,
 * field positions, reset values and timing counts.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

// ==========================================
// register word indexes (byte address = 4 * index)
`define IDX_CTRL 8'h00
`define IDX_FLAGS 8'h01
`define IDX_IP 8'h02
`define IDX_MC0 8'h03
`define IDX_PFA 8'h04
`define IDX_PDB 8'h05
`define IDX_EXT 8'h06
`define IDX_ACC 8'h07
`define IDX_ID 8'h08
`define IDX_FCW 8'h09
`define IDX_FSW 8'h0A
`define IDX_FTW 8'h0B
`define IDX_FSEL 8'h0C
`define IDX_FOPP 8'h0D
`define IDX_FIPP 8'h0E
// groups: upper index bits
`define GRP_GP 5'h02
`define GRP_SEG 3'h1
`define GRP_FST 3'h2
`define GRP_PKD 4'h6
`define GRP_WIDE 3'h4
`define NUM_GP 3'h6
`define NUM_SEG 3'h6
`define SEG_F_SEL 2'h0
`define SEG_F_BASE 2'h1
`define SEG_F_LIMIT 2'h2

// ==========================================
// control / status bits
`define CTRL_FPU_INIT 0
`define CTRL_WARM 1

// ==========================================
// reset values
`define FLAGS_RESET 32'h00000002
`define IP_RESET 32'h0000FFF0
`define MC0_RESET 32'h60000010
`define MC0_KEEP_MASK 32'h60000000
`define ZERO_WORD 32'h00000000
`define CS_SEL_RESET 16'hF000
`define CS_BASE_RESET 32'hFFFF0000
`define SEG_LIMIT_RESET 32'h0000FFFF
`define SEG_ATTR_RESET 8'h93
`define FCW_RESET 16'h0040
`define FCW_INIT 16'h037F
`define FSW_RESET 16'h0000
`define FTW_RESET 16'h5555
`define FTW_INIT 16'hFFFF
`define SEL_ZERO 16'h0000
`define POST_FAIL_CODE 32'h00000001
// identification fields, values arbitrary
`define ID_STEPPING 4'h1
`define ID_MODEL 4'h2
`define ID_FAMILY 4'h3
`define ID_TYPE 2'h0
`define ID_EXT_MODEL 4'h0
`define ID_EXT_FAMILY 8'h00

// ==========================================
// timing
`define POST_PERIODS_DEFAULT 30000000
`define POST_CNT_W 25

`endif

// >>> include/reset_seq_pkg.sv
/*
 * Types of the reset and self-test sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package reset_seq_pkg;

	// ==========================================
	// sequencer states
	typedef enum logic [3:0] {
		st_apply = 4'b0001,
		st_post = 4'b0010,
		st_run = 4'b0100,
		st_warm = 4'b1000
	} seq_state_e;

	// ==========================================
	// segment register with hidden part
	typedef struct packed {
		logic [15:0] sel;
		logic [31:0] base;
		logic [31:0] limit;
		logic [7:0] attr;
	} seg_s;

endpackage

// >>> logic/reset_sequencer.sv
/*
 * Reset and self-test sequencer: holds the core's architectural state,
 * loads it on hardware reset, runs the optional power-on self-test,
 * handles warm restart and the soft floating-point initialise operation.
 * Assumes an Avalon-MM master on core_clk, asynchronous self_test_req and
 * warm_restart pins, and same-clock strobes from the core.
 */
// Functional notes
// R1 - self-test requested and passed: accumulator holds zero afterwards
// R2 - self-test finds a fault: accumulator holds a nonzero code afterwards
// R3 - no self-test requested: hardware reset loads accumulator with zero
// R4 - self-test runs about thirty million clocks; core held off meanwhile
// R5 - reset sets processor flags to 00000002H
// R6 - reset sets instruction pointer to 0000FFF0H
// R7 - reset sets primary machine control to 60000010H
// R8 - reset clears page-fault address, page-directory base, extension control
// R9 - reset: code segment F000H, base FFFF0000H, limit FFFFH, present rw accessed
// R10 - reset: stack and data segments zero selector and base, limit FFFFH
// R11 - reset clears the remaining general registers
// R12 - reset zeroes floating stack; soft initialise leaves it alone
// R13 - floating control word 0040H on reset, 037FH on soft initialise
// R14 - floating status word zero after reset and soft initialise
// R15 - floating tag word 5555H on reset, FFFFH on soft initialise
// R16 - floating last operand and instruction selectors cleared by both
// R17 - floating last operand and instruction pointers cleared by both
// R18 - packed-integer registers zeroed on reset; warm and soft keep them
// R19 - wide vector registers zeroed on reset; warm restart keeps them
// R20 - warm restart keeps floating state, invalidates translation buffers
// R21 - self-test only after hardware reset, never after warm restart
// R22 - identification register holds model, family, type and stepping
// R23 - all values applied before first fetch; release after verdict
// R24 - platform holds the self-test request stable until reset release
`timescale 1ns/100ps
`include "reset_seq_defs.svh"

module reset_sequencer
	import reset_seq_pkg::*;
#(
	parameter int unsigned POST_PERIODS = `POST_PERIODS_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic self_test_req,
	input wire logic warm_restart,
	input wire logic soft_fpu_initialise_op,
	input wire logic self_test_fault,
	output logic core_run,
	output logic tlb_btb_invalidate
);

	// ==========================================
	// state
	seq_state_e state_reg;
	seq_state_e state_next;
	logic [`POST_CNT_W-1:0] post_cnt_reg;
	logic post_req_reg;
	logic post_done_reg;
	logic post_fail_reg;
	logic fault_seen_reg;
	logic run_reg;
	logic inv_reg;
	logic req_meta_reg;
	logic req_sync_reg;
	logic warm_meta_reg;
	logic warm_sync_reg;
	logic warm_prev_reg;
	logic ack_reg;
	logic [31:0] readdata_reg;

	logic [31:0] processor_flags_reg;
	logic [31:0] instruction_pointer_reg;
	logic [31:0] machine_control_primary_reg;
	logic [31:0] page_fault_address_reg;
	logic [31:0] page_directory_base_reg;
	logic [31:0] extension_control_reg;
	logic [31:0] accumulator_reg;
	logic [31:0] identification_reg;
	logic [31:0] gp_reg [0:5];
	seg_s seg_reg [0:5];
	logic [15:0] fpu_control_word_reg;
	logic [15:0] fpu_status_word_reg;
	logic [15:0] fpu_tag_word_reg;
	logic [15:0] fpu_op_sel_reg;
	logic [15:0] fpu_inst_sel_reg;
	logic [31:0] fpu_op_ptr_reg;
	logic [31:0] fpu_inst_ptr_reg;
	logic [79:0] fpu_stack_reg [0:7];
	logic [63:0] packed_integer_reg [0:7];
	logic [127:0] wide_vector_reg [0:7];

	// ==========================================
	// bus decode
	logic [7:0] idx;
	logic req_any;
	logic wr_go;
	logic rd_go;
	logic is_gp;
	logic is_seg;
	logic is_fst;
	logic is_pkd;
	logic is_wide;
	logic [2:0] grp_i;
	logic [1:0] fld;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic ctrl_wr;
	logic warm_go;
	logic warm_apply;
	logic fpu_init_go;
	logic post_end;
	logic [31:0] id_value;

	assign idx = avs_address[9:2];
	assign req_any = avs_read | avs_write;
	assign avs_waitrequest = req_any & ~ack_reg;
	assign rd_go = avs_read & ~ack_reg;
	// writes land at the edge where waitrequest is seen low
	assign wr_go = avs_write & ack_reg;
	assign avs_readdata = readdata_reg;
	assign is_gp = (idx[7:3] == `GRP_GP) && (idx[2:0] < `NUM_GP);
	assign is_seg = (idx[7:5] == `GRP_SEG) && (idx[4:2] < `NUM_SEG);
	assign is_fst = idx[7:5] == `GRP_FST;
	assign is_pkd = idx[7:4] == `GRP_PKD;
	assign is_wide = idx[7:5] == `GRP_WIDE;
	assign grp_i = is_pkd ? idx[3:1] : (is_gp ? idx[2:0] : idx[4:2]);
	assign fld = is_pkd ? {1'b0, idx[0]} : idx[1:0];
	assign ctrl_wr = wr_go && (idx == `IDX_CTRL) && avs_byteenable[0];

	assign warm_go = (warm_sync_reg & ~warm_prev_reg) | (ctrl_wr & avs_writedata[`CTRL_WARM]);
	assign warm_apply = (state_reg == st_run) & warm_go;
	assign fpu_init_go = soft_fpu_initialise_op | (ctrl_wr & avs_writedata[`CTRL_FPU_INIT]);
	assign post_end = (state_reg == st_post) && (post_cnt_reg == `POST_CNT_W'(POST_PERIODS - 1));
	assign id_value = {4'h0, `ID_EXT_FAMILY, `ID_EXT_MODEL, 2'h0, `ID_TYPE,
		`ID_FAMILY, `ID_MODEL, `ID_STEPPING}; // R22

	assign core_run = run_reg;
	assign tlb_btb_invalidate = inv_reg;

	// ==========================================
	// read mux of the addressed word
	always_comb begin
		rd_word = `ZERO_WORD;
		case (idx)
			`IDX_CTRL: rd_word = {27'h0, post_fail_reg, post_done_reg, post_req_reg,
				state_reg == st_post, run_reg};
			`IDX_FLAGS: rd_word = processor_flags_reg;
			`IDX_IP: rd_word = instruction_pointer_reg;
			`IDX_MC0: rd_word = machine_control_primary_reg;
			`IDX_PFA: rd_word = page_fault_address_reg;
			`IDX_PDB: rd_word = page_directory_base_reg;
			`IDX_EXT: rd_word = extension_control_reg;
			`IDX_ACC: rd_word = accumulator_reg;
			`IDX_ID: rd_word = identification_reg;
			`IDX_FCW: rd_word = {16'h0, fpu_control_word_reg};
			`IDX_FSW: rd_word = {16'h0, fpu_status_word_reg};
			`IDX_FTW: rd_word = {16'h0, fpu_tag_word_reg};
			`IDX_FSEL: rd_word = {fpu_inst_sel_reg, fpu_op_sel_reg};
			`IDX_FOPP: rd_word = fpu_op_ptr_reg;
			`IDX_FIPP: rd_word = fpu_inst_ptr_reg;
			default: begin
				if (is_gp) begin
					rd_word = gp_reg[grp_i];
				end else if (is_seg) begin
					case (fld)
						`SEG_F_SEL: rd_word = {16'h0, seg_reg[grp_i].sel};
						`SEG_F_BASE: rd_word = seg_reg[grp_i].base;
						`SEG_F_LIMIT: rd_word = seg_reg[grp_i].limit;
						default: rd_word = {24'h0, seg_reg[grp_i].attr};
					endcase
				end else if (is_fst) begin
					case (fld)
						2'h0: rd_word = fpu_stack_reg[grp_i][31:0];
						2'h1: rd_word = fpu_stack_reg[grp_i][63:32];
						2'h2: rd_word = {16'h0, fpu_stack_reg[grp_i][79:64]};
						default: rd_word = `ZERO_WORD;
					endcase
				end else if (is_pkd) begin
					rd_word = packed_integer_reg[grp_i][32*fld[0] +: 32];
				end else if (is_wide) begin
					rd_word = wide_vector_reg[grp_i][32*fld +: 32];
				end
			end
		endcase
	end

	// byte lanes merged into the current word
	always_comb begin
		wr_word = rd_word;
		for (int b = 0; b < 4; b++) begin
			if (avs_byteenable[b]) begin
				wr_word[8*b +: 8] = avs_writedata[8*b +: 8];
			end
		end
	end

	// ==========================================
	// bus handshake: one wait cycle per access
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			ack_reg <= 1'b0;
			readdata_reg <= `ZERO_WORD;
		end else begin
			ack_reg <= req_any & ~ack_reg;
			if (rd_go) begin
				readdata_reg <= rd_word;
			end
		end
	end

	// ==========================================
	// pin synchronisers
	always_ff @(posedge core_clk) begin
		req_meta_reg <= self_test_req;
		req_sync_reg <= req_meta_reg;
		warm_meta_reg <= warm_restart;
		warm_sync_reg <= warm_meta_reg;
	end

	// a pin held high through reset gives no restart
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			warm_prev_reg <= 1'b1;
		end else begin
			warm_prev_reg <= warm_sync_reg;
		end
	end

	// ==========================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			st_apply: state_next = req_sync_reg ? st_post : st_run; // R21 R24
			st_post: state_next = post_end ? st_run : st_post; // R4 R23
			st_run: state_next = warm_go ? st_warm : st_run;
			st_warm: state_next = st_run; // R21
			default: state_next = st_apply;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_reg <= st_apply;
			run_reg <= 1'b0;
			inv_reg <= 1'b1;
		end else begin
			state_reg <= state_next;
			run_reg <= state_next == st_run; // R23
			inv_reg <= warm_apply; // R20
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			post_cnt_reg <= '0;
			post_req_reg <= 1'b0;
			post_done_reg <= 1'b0;
			post_fail_reg <= 1'b0;
			fault_seen_reg <= 1'b0;
		end else if (state_reg == st_apply) begin
			post_req_reg <= req_sync_reg;
		end else if (state_reg == st_post) begin
			post_cnt_reg <= post_cnt_reg + 1'b1; // R4
			fault_seen_reg <= fault_seen_reg | self_test_fault;
			if (post_end) begin
				post_done_reg <= 1'b1;
				post_fail_reg <= fault_seen_reg | self_test_fault;
			end
		end
	end

	// ==========================================
	// accumulator and identification
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			accumulator_reg <= `ZERO_WORD; // R3
			identification_reg <= `ZERO_WORD;
		end else if (state_reg == st_apply || warm_apply) begin
			identification_reg <= id_value; // R22
			accumulator_reg <= `ZERO_WORD; // R3
		end else if (post_end) begin
			if (fault_seen_reg | self_test_fault) begin
				accumulator_reg <= `POST_FAIL_CODE; // R2
			end else begin
				accumulator_reg <= `ZERO_WORD; // R1
			end
		end else if (wr_go) begin
			if (idx == `IDX_ACC) begin
				accumulator_reg <= wr_word;
			end
			if (idx == `IDX_ID) begin
				identification_reg <= wr_word;
			end
		end
	end

	// ==========================================
	// architectural state, loaded by reset and warm restart
	always_ff @(posedge core_clk) begin
		if (!rst_b || warm_apply) begin
			processor_flags_reg <= `FLAGS_RESET; // R5
			instruction_pointer_reg <= `IP_RESET; // R6
			page_fault_address_reg <= `ZERO_WORD; // R8
			page_directory_base_reg <= `ZERO_WORD; // R8
			extension_control_reg <= `ZERO_WORD; // R8
			for (int i = 0; i < 6; i++) begin
				gp_reg[i] <= `ZERO_WORD; // R11
				seg_reg[i].sel <= `SEL_ZERO; // R10
				seg_reg[i].base <= `ZERO_WORD; // R10
				seg_reg[i].limit <= `SEG_LIMIT_RESET; // R9 R10
				seg_reg[i].attr <= `SEG_ATTR_RESET; // R9 R10
			end
			seg_reg[0].sel <= `CS_SEL_RESET; // R9
			seg_reg[0].base <= `CS_BASE_RESET; // R9
		end else if (wr_go) begin
			unique case (1'b1)
				idx == `IDX_FLAGS: processor_flags_reg <= wr_word | `FLAGS_RESET;
				idx == `IDX_IP: instruction_pointer_reg <= wr_word;
				idx == `IDX_PFA: page_fault_address_reg <= wr_word;
				idx == `IDX_PDB: page_directory_base_reg <= wr_word;
				idx == `IDX_EXT: extension_control_reg <= wr_word;
				is_gp: gp_reg[grp_i] <= wr_word;
				is_seg: begin
					case (fld)
						`SEG_F_SEL: seg_reg[grp_i].sel <= wr_word[15:0];
						`SEG_F_BASE: seg_reg[grp_i].base <= wr_word;
						`SEG_F_LIMIT: seg_reg[grp_i].limit <= wr_word;
						default: seg_reg[grp_i].attr <= wr_word[7:0];
					endcase
				end
				default: begin
				end
			endcase
		end
	end

	// cache control bits survive a warm restart
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			machine_control_primary_reg <= `MC0_RESET; // R7
		end else if (warm_apply) begin
			machine_control_primary_reg <= (machine_control_primary_reg & `MC0_KEEP_MASK)
				| (`MC0_RESET & ~`MC0_KEEP_MASK);
		end else if (wr_go && idx == `IDX_MC0) begin
			machine_control_primary_reg <= wr_word;
		end
	end

	// ==========================================
	// floating-point environment, untouched by warm restart
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			fpu_control_word_reg <= `FCW_RESET; // R13
			fpu_status_word_reg <= `FSW_RESET; // R14
			fpu_tag_word_reg <= `FTW_RESET; // R15
			fpu_op_sel_reg <= `SEL_ZERO; // R16
			fpu_inst_sel_reg <= `SEL_ZERO; // R16
			fpu_op_ptr_reg <= `ZERO_WORD; // R17
			fpu_inst_ptr_reg <= `ZERO_WORD; // R17
		end else if (fpu_init_go) begin
			fpu_control_word_reg <= `FCW_INIT; // R13
			fpu_status_word_reg <= `FSW_RESET; // R14
			fpu_tag_word_reg <= `FTW_INIT; // R15
			fpu_op_sel_reg <= `SEL_ZERO; // R16
			fpu_inst_sel_reg <= `SEL_ZERO; // R16
			fpu_op_ptr_reg <= `ZERO_WORD; // R17
			fpu_inst_ptr_reg <= `ZERO_WORD; // R17
		end else if (wr_go) begin
			case (idx)
				`IDX_FCW: fpu_control_word_reg <= wr_word[15:0];
				`IDX_FSW: fpu_status_word_reg <= wr_word[15:0];
				`IDX_FTW: fpu_tag_word_reg <= wr_word[15:0];
				`IDX_FSEL: begin
					fpu_op_sel_reg <= wr_word[15:0];
					fpu_inst_sel_reg <= wr_word[31:16];
				end
				`IDX_FOPP: fpu_op_ptr_reg <= wr_word;
				`IDX_FIPP: fpu_inst_ptr_reg <= wr_word;
				default: begin
				end
			endcase
		end
	end

	// ==========================================
	// register banks: cleared only by hardware reset
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			for (int i = 0; i < 8; i++) begin
				fpu_stack_reg[i] <= '0; // R12
				packed_integer_reg[i] <= '0; // R18
				wide_vector_reg[i] <= '0; // R19
			end
		end else if (wr_go) begin
			// soft initialise and warm restart never reach here: R12 R18 R19 R20
			if (is_fst) begin
				case (fld)
					2'h0: fpu_stack_reg[grp_i][31:0] <= wr_word;
					2'h1: fpu_stack_reg[grp_i][63:32] <= wr_word;
					2'h2: fpu_stack_reg[grp_i][79:64] <= wr_word[15:0];
					default: begin
					end
				endcase
			end else if (is_pkd) begin
				packed_integer_reg[grp_i][32*fld[0] +: 32] <= wr_word;
			end else if (is_wide) begin
				wide_vector_reg[grp_i][32*fld +: 32] <= wr_word;
			end
		end
	end

endmodule

// >>> sim/platform_model.sv
/* Platform side: hardware reset, self-test request and fault, warm restart pin.
 * Assumes the bench calls hard_reset and warm_pulse. */
`timescale 1ns/100ps
module platform_model (
	input wire logic core_clk,
	input wire logic core_run,
	output logic rst_b,
	output logic self_test_req,
	output logic self_test_fault,
	output logic warm_restart
);
	// ==========================================
	// pins
	logic fault_en;
	initial begin
		rst_b = 1'b0;
		self_test_req = 1'b0;
		self_test_fault = 1'b0;
		warm_restart = 1'b0;
		fault_en = 1'b0;
	end
	// fault reported for the whole time the core is held off
	always @(posedge core_clk) self_test_fault <= fault_en && rst_b && !core_run;
	// request set with reset and held until the next reset
	task automatic hard_reset(input logic post, input logic fault);
		rst_b <= 1'b0;
		self_test_req <= post;
		fault_en <= fault;
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
	endtask
	task automatic warm_pulse();
		@(posedge core_clk);
		warm_restart <= 1'b1;
		repeat (4) @(posedge core_clk);
		warm_restart <= 1'b0;
	endtask
endmodule

// >>> sim/reset_sequencer_checker.sv
/* Port checker of the reset sequencer: bus wait, release timing, invalidate pulse.
 * Assumes binding to reset_sequencer with the same POST_PERIODS. */
`timescale 1ns/100ps
module reset_sequencer_checker
	import reset_seq_pkg::*;
#(
	parameter int unsigned POST_PERIODS = 20
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic self_test_req,
	input wire logic warm_restart,
	input wire logic soft_fpu_initialise_op,
	input wire logic self_test_fault,
	input wire logic core_run,
	input wire logic tlb_btb_invalidate
);
	// ==========================================
	// helpers: cycles held off since release, captured request
	logic [31:0] low_cnt_reg;
	logic req_reg;
	logic seen_reg;
	always_ff @(posedge core_clk) begin
		if (!rst_b) low_cnt_reg <= 32'h0;
		else if (!core_run) low_cnt_reg <= low_cnt_reg + 32'h1;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) req_reg <= self_test_req;
	end
	always_ff @(posedge core_clk) begin
		if (!rst_b) seen_reg <= 1'b0;
		else if (core_run) seen_reg <= 1'b1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	init_outputs_a: assert property ($rose(rst_b) |-> !core_run && tlb_btb_invalidate && avs_readdata == 32'h0)
		else $error("outputs not in reset state at release");
	first_wait_a: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
		else $error("no wait cycle at start of access");
	one_wait_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("access not answered after one wait cycle");
	inval_pulse_a: assert property ($rose(tlb_btb_invalidate) |-> !core_run ##1 (core_run && !tlb_btb_invalidate))
		else $error("warm restart not a one cycle hold");
	run_fall_a: assert property ($fell(core_run) |-> tlb_btb_invalidate)
		else $error("core stopped without invalidate");
	inval_core_a: assert property (tlb_btb_invalidate |-> !core_run)
		else $error("core runs during invalidate");
	post_length_a: assert property ($rose(core_run) && !seen_reg |-> low_cnt_reg == (req_reg ? POST_PERIODS + 1 : 1))
		else $error("core released at wrong cycle");
	rdata_hold_a: assert property ($changed(avs_readdata) |-> $past(avs_read && avs_waitrequest))
		else $error("read data changed outside a read");
	cover property ($rose(core_run) && req_reg);
	cover property ($rose(tlb_btb_invalidate));
	cover property (avs_write && !avs_waitrequest);
endmodule
bind reset_sequencer reset_sequencer_checker #(.POST_PERIODS(POST_PERIODS)) u_reset_sequencer_checker (
	.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest), .self_test_req(self_test_req), .warm_restart(warm_restart),
	.soft_fpu_initialise_op(soft_fpu_initialise_op), .self_test_fault(self_test_fault), .core_run(core_run),
	.tlb_btb_invalidate(tlb_btb_invalidate)
);

// >>> sim/reset_sequencer_tb.sv
/* Self-checking bench of the reset sequencer over Avalon-MM.
 * Assumes the checker is bound and platform_model drives reset pins. */
`timescale 1ns/100ps
`include "reset_seq_defs.svh"
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin errors++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module reset_sequencer_tb;
	localparam int unsigned POST_N = 20;
	logic core_clk, rst_b, avs_read, avs_write, self_test_req, warm_restart, soft_op, self_test_fault;
	logic [9:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata;
	logic avs_waitrequest, core_run, tlb_btb_invalidate;
	int errors = 0;
	int checks_done = 0;
	reset_sequencer #(.POST_PERIODS(POST_N)) u_reset_sequencer (.core_clk(core_clk), .rst_b(rst_b),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.self_test_req(self_test_req), .warm_restart(warm_restart), .soft_fpu_initialise_op(soft_op),
		.self_test_fault(self_test_fault), .core_run(core_run), .tlb_btb_invalidate(tlb_btb_invalidate));
	platform_model u_platform_model (.core_clk(core_clk), .core_run(core_run), .rst_b(rst_b),
		.self_test_req(self_test_req), .self_test_fault(self_test_fault), .warm_restart(warm_restart));
	// ==========================================
	// bus tasks
	task automatic bus_xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		logic w;
		n = 0;
		w = 1'b1;
		@(posedge core_clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		while (w === 1'b1 && n < 20) begin
			@(posedge core_clk);
			w = avs_waitrequest;
			rd = avs_readdata;
			n++;
		end
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		`CHECK(w, 1'b0)
	endtask
	task automatic wr(input logic [7:0] idx, input logic [31:0] d);
		logic [31:0] x;
		bus_xfer(1'b1, idx, d, x);
	endtask
	task automatic chk(input logic [7:0] idx, input logic [31:0] exp);
		logic [31:0] d;
		bus_xfer(1'b0, idx, 32'h0, d);
		`CHECK(d, exp)
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset_values();
		int i;
		u_platform_model.hard_reset(1'b0, 1'b0);
		chk(`IDX_FLAGS, `FLAGS_RESET);
		chk(`IDX_IP, `IP_RESET);
		chk(`IDX_MC0, `MC0_RESET);
		for (i = 4; i < 7; i++) chk(8'(i), `ZERO_WORD);
		chk(`IDX_ACC, `ZERO_WORD);
		chk(`IDX_ID, {4'h0, `ID_EXT_FAMILY, `ID_EXT_MODEL, 2'h0, `ID_TYPE, `ID_FAMILY, `ID_MODEL, `ID_STEPPING});
		chk(`IDX_FCW, {16'h0, `FCW_RESET});
		chk(`IDX_FSW, 32'h0);
		chk(`IDX_FTW, {16'h0, `FTW_RESET});
		chk(`IDX_FSEL, 32'h0);
		chk(`IDX_FOPP, 32'h0);
		chk(`IDX_FIPP, 32'h0);
		for (i = 16; i < 22; i++) chk(8'(i), 32'h0);
		for (i = 0; i < 6; i++) begin
			chk(8'(32 + 4 * i), i == 0 ? {16'h0, `CS_SEL_RESET} : 32'h0);
			chk(8'(33 + 4 * i), i == 0 ? `CS_BASE_RESET : 32'h0);
			chk(8'(34 + 4 * i), `SEG_LIMIT_RESET);
			chk(8'(35 + 4 * i), {24'h0, `SEG_ATTR_RESET});
		end
		for (i = 64; i < 96; i++) chk(8'(i), 32'h0);
		for (i = 96; i < 112; i++) chk(8'(i), 32'h0);
		for (i = 128; i < 160; i++) chk(8'(i), 32'h0);
		wr(8'hF0, 32'hFFFFFFFF);
		chk(8'hF0, 32'h0);
		chk(`IDX_CTRL, 32'h1);
		$display("test reset_values done");
	endtask
	task automatic t_warm(input logic pin);
		wr(`IDX_MC0, 32'h0);
		wr(`IDX_IP, 32'h1234);
		wr(8'h10, 32'h55);
		wr(`IDX_FCW, 32'h0ABC);
		wr(8'h41, 32'hA5A5A5A5);
		wr(8'h61, 32'h5A5A5A5A);
		wr(8'h83, 32'h3C3C3C3C);
		wr(`IDX_FLAGS, 32'h0);
		chk(`IDX_FLAGS, `FLAGS_RESET);
		if (pin) u_platform_model.warm_pulse();
		else wr(`IDX_CTRL, 32'h2);
		chk(`IDX_IP, `IP_RESET);
		chk(`IDX_MC0, 32'h00000010);
		chk(8'h10, 32'h0);
		chk(`IDX_FCW, 32'h0ABC);
		chk(8'h41, 32'hA5A5A5A5);
		chk(8'h61, 32'h5A5A5A5A);
		chk(8'h83, 32'h3C3C3C3C);
		chk(`IDX_CTRL, 32'h1);
		$display("test warm done");
	endtask
	task automatic t_soft(input logic pin);
		wr(`IDX_FCW, 32'h1111);
		wr(`IDX_FSW, 32'h2222);
		wr(`IDX_FTW, 32'h3333);
		wr(`IDX_FSEL, 32'h44445555);
		wr(`IDX_FOPP, 32'h6);
		wr(`IDX_FIPP, 32'h7);
		wr(8'h42, 32'h9);
		wr(8'h62, 32'h8);
		if (pin) begin
			@(posedge core_clk);
			soft_op <= 1'b1;
			@(posedge core_clk);
			soft_op <= 1'b0;
		end else wr(`IDX_CTRL, 32'h1);
		chk(`IDX_FCW, {16'h0, `FCW_INIT});
		chk(`IDX_FSW, 32'h0);
		chk(`IDX_FTW, {16'h0, `FTW_INIT});
		chk(`IDX_FSEL, 32'h0);
		chk(`IDX_FOPP, 32'h0);
		chk(`IDX_FIPP, 32'h0);
		chk(8'h42, 32'h9);
		chk(8'h62, 32'h8);
		$display("test soft_init done");
	endtask
	task automatic t_post(input logic fault);
		int n;
		logic [31:0] d;
		n = 0;
		u_platform_model.hard_reset(1'b1, fault);
		while (n < 200) begin
			@(posedge core_clk);
			n++;
			@(negedge core_clk);
			if (core_run === 1'b1) break;
		end
		`CHECK(n, POST_N + 1)
		bus_xfer(1'b0, `IDX_ACC, 32'h0, d);
		if (fault) `CHECK(d != 32'h0, 1'b1)
		else `CHECK(d, 32'h0)
		chk(`IDX_CTRL, {27'h0, fault, 4'hD});
		chk(`IDX_FCW, {16'h0, `FCW_RESET});
		chk(8'h62, 32'h0);
		chk(8'h83, 32'h0);
		$display("test self_test done");
	endtask
	// ==========================================
	// run control
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	initial begin
		#500000;
		errors++;
		final_report();
	end
	initial begin
		avs_address = 10'h0;
		avs_writedata = 32'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		soft_op = 1'b0;
		t_reset_values();
		t_warm(1'b0);
		t_warm(1'b1);
		t_soft(1'b0);
		t_soft(1'b1);
		t_post(1'b0);
		t_post(1'b1);
		final_report();
	end
endmodule
